// File: logic/amc_core.sv
`timescale 1ns/100ps
module amc_core
  import amc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output      logic [31:0]       hrdata,
  output      logic              hreadyout,
  output      logic              hresp,
  input  wire logic              conv_out_of_range,
  input  wire logic              conv_negative,
  output      logic              master_clock_output_oe,
  output      logic              master_clock_output_pin,
  output      logic              oscillator_enable,
  output      logic              rdy_n,
  output      logic              conv_done,
  output      logic              conv_channel,
  output      logic              cal_done,
  output      logic              data_width_24,
  output      logic              status_chain_read,
  output      logic              continuous_read,
  output      logic              clamp_force,
  output      logic              clamp_high
);

  initial begin
    if (ADDR_W < 8) $error("amc_core: ADDR_W must be at least 8");
  end

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic [7:0]  ct0;
    logic [7:0]  ct1;
    logic [7:0]  setup0;
    logic [7:0]  setup1;
    logic [7:0]  mode;
    logic        xtal;
    logic [1:0]  ready;
    logic        rdy_n;
    amc_state_t  state;
    logic        chan;
    logic [15:0] cnt;
    logic [1:0]  cal_left;
    logic        done_p;
    logic        done_ch;
    logic        cal_p;
    logic        clkdiv;
    logic        oor;
    logic        neg;
  } amc_regs_t;

  amc_regs_t r_reg;
  amc_regs_t r_next;

  logic [7:0]  ct_sel;
  logic [6:0]  fw_sel;
  logic        two_en;
  logic [15:0] len_sel;
  logic        halted;
  logic        rd_sel;
  logic        wr_sel;
  logic [7:0]  wa;
  logic [7:0]  wd;
  logic        mode_wr;
  logic        nxt_ch;
  logic        oor_s1;
  logic        neg_s1;

  // Length of one conversion for the given channel
  function automatic logic [15:0] conv_len(input logic [7:0] ct, input logic two);
    logic [15:0] fw;
    logic [6:0]  f;
    f  = ct[6:0];
    if (ct[CT_CHOPPING_ENABLE_BIT]) begin
      if (f < FW_MIN_CHOPPING_ENABLE) f = FW_MIN_CHOPPING_ENABLE;
      fw = {9'h000, f};
      conv_len = fw * CHOPPING_ENABLE_MULT + (two ? CHOPPING_ENABLE_OFS2 : CHOPPING_ENABLE_OFS1);
    end else begin
      if (f < FW_MIN_NOCHOP) f = FW_MIN_NOCHOP;
      fw = {9'h000, f};
      conv_len = fw * NOCHOP_MULT + (two ? NOCHOP_OFS2 : NOCHOP_OFS1);
    end
  endfunction : conv_len

  always_comb begin
    two_en  = r_reg.setup0[SETUP_EN_BIT] && r_reg.setup1[SETUP_EN_BIT]
              && (r_reg.mode[MODE_MSB:MODE_LSB] == MD_CONT);
    ct_sel  = r_reg.chan ? r_reg.ct1 : r_reg.ct0;
    fw_sel  = ct_sel[6:0];
    len_sel = conv_len(ct_sel, two_en);
    halted  = r_reg.xtal && r_reg.mode[CLOCK_OUTPUT_DISABLE_BIT];
    rd_sel  = hsel && hready && htrans[1] && !hwrite;
    wr_sel  = hsel && hready && htrans[1] && hwrite;
    wa      = r_reg.wr_addr;
    wd      = hwdata[7:0];
    mode_wr = r_reg.wr_pend && (wa == ADDR_MODE || wa == ADDR_MODE_CH1);
    // Next enabled channel, staying on the current one if only it is enabled
    nxt_ch  = r_reg.chan;
    if (r_reg.chan ? r_reg.setup0[SETUP_EN_BIT] : r_reg.setup1[SETUP_EN_BIT]) begin
      nxt_ch = ~r_reg.chan;
    end
  end

  always_comb begin
    r_next          = r_reg;
    r_next.done_p   = 1'b0;
    r_next.cal_p    = 1'b0;
    r_next.wr_pend  = wr_sel;
    r_next.oor      = oor_s1;
    r_next.neg      = neg_s1;
    r_next.clkdiv   = ~r_reg.clkdiv;
    if (wr_sel) begin
      r_next.wr_addr = haddr[9:2];
    end
    if (rd_sel) begin
      case (haddr[9:2])
        ADDR_CONV_TIME0:  r_next.rdata = {24'h000000, r_reg.ct0};
        ADDR_CONV_TIME1:  r_next.rdata = {24'h000000, r_reg.ct1};
        ADDR_MODE:        r_next.rdata = {24'h000000, r_reg.mode};
        ADDR_CHAN_SETUP0: r_next.rdata = {24'h000000, r_reg.setup0};
        ADDR_CHAN_SETUP1: r_next.rdata = {24'h000000, r_reg.setup1};
        ADDR_CONV_STATUS: r_next.rdata = {24'h000000, 1'b0, r_reg.rdy_n, r_reg.state,
                                          r_reg.chan, r_reg.chan, r_reg.ready};
        ADDR_CONV_CTRL:   r_next.rdata = {31'h00000000, r_reg.xtal};
        default:          r_next.rdata = 32'h00000000;
      endcase
    end

    // Conversion sequencing
    if (!halted) begin
      case (r_reg.state)
        ST_CONV: begin
          if (r_reg.cnt > 16'h0001) begin
            r_next.cnt = r_reg.cnt - 16'h0001;
          end else begin
            r_next.done_p  = 1'b1;
            r_next.done_ch = r_reg.chan;
            r_next.ready[r_reg.chan] = 1'b1;
            if (r_reg.mode[MODE_MSB:MODE_LSB] == MD_SINGLE) begin
              r_next.rdy_n = 1'b0;
              r_next.mode[MODE_MSB:MODE_LSB] = MD_IDLE;
              r_next.state = ST_IDLE;
            end else begin
              r_next.rdy_n = 1'b0;
              r_next.chan  = nxt_ch;
              r_next.cnt   = conv_len(nxt_ch ? r_reg.ct1 : r_reg.ct0, two_en);
            end
          end
        end
        ST_CAL: begin
          if (r_reg.cnt > 16'h0001) begin
            r_next.cnt = r_reg.cnt - 16'h0001;
          end else if (r_reg.cal_left > 2'h1) begin
            r_next.cal_left = r_reg.cal_left - 2'h1;
            r_next.cnt      = len_sel;
          end else begin
            r_next.cal_p = 1'b1;
            r_next.mode[MODE_MSB:MODE_LSB] = MD_IDLE;
            r_next.state = ST_IDLE;
          end
        end
        default: begin
          r_next.state = ST_IDLE;
        end
      endcase
    end

    if (r_reg.wr_pend) begin
      case (wa)
        ADDR_CONV_TIME0:  r_next.ct0 = wd;
        ADDR_CONV_TIME1:  r_next.ct1 = wd;
        ADDR_CHAN_SETUP0: r_next.setup0 = wd;
        ADDR_CHAN_SETUP1: r_next.setup1 = wd;
        ADDR_CONV_CTRL:   r_next.xtal = wd[CTRL_XTAL_BIT];
        default:          r_next.xtal = r_reg.xtal;
      endcase
    end

    if (mode_wr) begin
      r_next.mode  = wd;
      r_next.done_p = 1'b0;
      r_next.cal_p  = 1'b0;
      r_next.ready = 2'h0;
      r_next.rdy_n = 1'b1;
      r_next.chan  = wa[ADDR_CH_BIT];
      r_next.cal_left = 2'(CAL_CONVERSIONS);
      r_next.cnt   = conv_len(wa[ADDR_CH_BIT] ? r_reg.ct1 : r_reg.ct0,
                              (wd[MODE_MSB:MODE_LSB] == MD_CONT) &&
                              r_reg.setup0[SETUP_EN_BIT] && r_reg.setup1[SETUP_EN_BIT]);
      case (wd[MODE_MSB:MODE_LSB])
        MD_CONT, MD_SINGLE:           r_next.state = ST_CONV;
        MD_SELF_ZS, MD_SYS_ZS, MD_SYS_FS: r_next.state = ST_CAL;
        default:                      r_next.state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    oor_s1 <= conv_out_of_range;
    neg_s1 <= conv_negative;
    if (srst) begin
      r_reg        <= '0;
      r_reg.ct0    <= CONV_TIME_RESET;
      r_reg.ct1    <= CONV_TIME_RESET;
      r_reg.mode   <= MODE_RESET;
      r_reg.rdy_n  <= 1'b1;
      r_reg.state  <= ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  always_comb begin
    hrdata                  = r_reg.rdata;
    hreadyout               = 1'b1;
    hresp                   = 1'b0;
    master_clock_output_oe  = !r_reg.mode[CLOCK_OUTPUT_DISABLE_BIT];
    master_clock_output_pin = r_reg.clkdiv && !r_reg.mode[CLOCK_OUTPUT_DISABLE_BIT];
    oscillator_enable       = !halted;
    rdy_n                   = r_reg.rdy_n;
    conv_done               = r_reg.done_p;
    conv_channel            = r_reg.done_ch;
    cal_done                = r_reg.cal_p;
    data_width_24           = r_reg.mode[WIDTH24_BIT];
    continuous_read         = r_reg.mode[CONTRD_BIT];
    status_chain_read       = r_reg.mode[CHAIN_BIT] || r_reg.mode[CONTRD_BIT];
    clamp_force             = r_reg.mode[CLAMP_BIT] && r_reg.oor;
    clamp_high              = !r_reg.neg;
  end

endmodule : amc_core

// File: logic/amc_pkg.sv
package amc_pkg;
  // Register word addresses, compared with haddr[9:2]
  localparam logic [7:0] ADDR_CONV_TIME0  = 8'h30;
  localparam logic [7:0] ADDR_CONV_TIME1  = 8'h32;
  localparam logic [7:0] ADDR_MODE        = 8'h38;
  localparam logic [7:0] ADDR_MODE_CH1    = 8'h3A;
  localparam logic [7:0] ADDR_CHAN_SETUP0 = 8'h28;
  localparam logic [7:0] ADDR_CHAN_SETUP1 = 8'h2A;
  localparam logic [7:0] ADDR_CONV_STATUS = 8'h40;
  localparam logic [7:0] ADDR_CONV_CTRL   = 8'h44;
  // Reset values
  localparam logic [7:0] CONV_TIME_RESET  = 8'h91;
  localparam logic [7:0] MODE_RESET       = 8'h00;
  // Field positions
  localparam int CT_CHOPPING_ENABLE_BIT   = 7;
  localparam int MODE_MSB      = 7;
  localparam int MODE_LSB      = 5;
  localparam int CLOCK_OUTPUT_DISABLE_BIT    = 4;
  localparam int CHAIN_BIT     = 3;
  localparam int CONTRD_BIT    = 2;
  localparam int WIDTH24_BIT   = 1;
  localparam int CLAMP_BIT     = 0;
  localparam int SETUP_EN_BIT  = 3;
  localparam int ADDR_CH_BIT   = 1;
  localparam int CTRL_XTAL_BIT = 0;
  // Conversion time constants in master clock cycles
  localparam logic [15:0] CHOPPING_ENABLE_MULT   = 16'h0080;
  localparam logic [15:0] CHOPPING_ENABLE_OFS1   = 16'h00F8;
  localparam logic [15:0] CHOPPING_ENABLE_OFS2   = 16'h00F9;
  localparam logic [15:0] NOCHOP_MULT = 16'h0040;
  localparam logic [15:0] NOCHOP_OFS1 = 16'h00CE;
  localparam logic [15:0] NOCHOP_OFS2 = 16'h00CF;
  localparam logic [6:0]  FW_MIN_CHOPPING_ENABLE   = 7'h02;
  localparam logic [6:0]  FW_MIN_NOCHOP = 7'h03;
  // Self-calibration and system calibration lengths
  localparam int CAL_CONVERSIONS = 2;
  // Operating mode codes
  typedef enum logic [2:0] {
    MD_IDLE     = 3'h0,
    MD_CONT     = 3'h1,
    MD_SINGLE   = 3'h2,
    MD_STANDBY  = 3'h3,
    MD_SELF_ZS  = 3'h4,
    MD_RESV     = 3'h5,
    MD_SYS_ZS   = 3'h6,
    MD_SYS_FS   = 3'h7
  } amc_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_CAL
  } amc_state_t;
endpackage : amc_pkg

// File: verification/amc_front_model.sv
`timescale 1ns/100ps
module amc_front_model (
  input  wire logic mclk,
  input  wire logic conv_done,
  output      logic conv_out_of_range,
  output      logic conv_negative
);
  int seed = 32'h0000_5A5A;
  // New input level after every finished conversion
  initial {conv_out_of_range, conv_negative} = 2'h0;
  always @(posedge mclk) begin
    if (conv_done) {conv_out_of_range, conv_negative} <= 2'($random(seed));
  end
endmodule : amc_front_model

// File: verification/amc_monitor.sv
`timescale 1ns/100ps
module amc_monitor
  import amc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        rdy_n,
  input wire logic        conv_done,
  input wire logic        master_clock_output_oe,
  input wire logic        data_width_24,
  input wire logic        status_chain_read,
  input wire logic        continuous_read,
  input wire logic        clamp_force
);
  logic       wr_a;
  logic       wr_q;
  logic [7:0] md_q;
  assign wr_a = hsel & hready & htrans[1] & hwrite
              & (haddr[9:2] == ADDR_MODE || haddr[9:2] == ADDR_MODE_CH1);
  always_ff @(posedge mclk) begin
    wr_q <= srst ? 1'b0 : wr_a;
    md_q <= srst ? MODE_RESET : (wr_q ? hwdata[7:0] : md_q);
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_mode_wr;
    wr_a ##1 1'b1;
  endsequence
  sequence s_idle_wr;
    wr_a ##1 (hwdata[7:5] == 3'h0);
  endsequence
  chk_mode_ready: assert property (s_mode_wr |=> rdy_n)
    else $error("ready pin low after mode write");
  chk_idle_quiet: assert property (s_idle_wr |=> !conv_done [*8])
    else $error("conversion ended after idle write");
  chk_done_ready: assert property (conv_done && !wr_q |-> ##[0:1] !rdy_n)
    else $error("ready pin not low after conversion");
  chk_done_pulse: assert property (conv_done |=> !conv_done)
    else $error("conversion end not a pulse");
  chk_clk_oe: assert property (master_clock_output_oe == !md_q[CLOCK_OUTPUT_DISABLE_BIT])
    else $error("clock output enable wrong");
  chk_width_sel: assert property (data_width_24 == md_q[WIDTH24_BIT])
    else $error("data width wrong");
  chk_cont_read: assert property (continuous_read == md_q[CONTRD_BIT])
    else $error("continuous read wrong");
  chk_chain_read: assert property (status_chain_read == (md_q[3] || md_q[2]))
    else $error("chained read wrong");
  chk_clamp_cause: assert property (clamp_force |-> md_q[0] || $past(md_q[0]))
    else $error("clamp without clamp bit");
endmodule : amc_monitor
bind amc_core amc_monitor amc_monitor_i (.mclk, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .rdy_n, .conv_done, .master_clock_output_oe, .data_width_24, .status_chain_read,
  .continuous_read, .clamp_force);

// File: verification/tb_adc_mode_and_conversion_timing.sv
`timescale 1ns/100ps
module tb_adc_mode_and_conversion_timing;
  import amc_pkg::*;
  logic        mclk, srst, hsel, hwrite, hreadyout, oor, neg, osc, rdy_n, done, cal_done, ch;
  logic        conv_channel;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  md;
  logic [7:0]  sc [4];
  logic [7:0]  ra [5] = '{ADDR_CONV_TIME0, ADDR_CONV_TIME1, ADDR_MODE, ADDR_MODE_CH1, 8'h3C};
  logic [7:0]  re [5] = '{CONV_TIME_RESET, CONV_TIME_RESET, MODE_RESET, 8'h00, 8'h00};
  int          num_errors = 0;
  int          samples_checked = 0;
  int          seed = 32'he8655d16;
  int          cyc = 0;
  int          n;
  amc_core amc_core_i (.mclk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .conv_out_of_range(oor),
    .conv_negative(neg), .master_clock_output_oe(), .master_clock_output_pin(),
    .oscillator_enable(osc), .rdy_n, .conv_done(done), .conv_channel, .cal_done,
    .data_width_24(), .status_chain_read(), .continuous_read(), .clamp_force(), .clamp_high());
  amc_front_model amc_front_model_i (.mclk, .conv_done(done), .conv_out_of_range(oor),
    .conv_negative(neg));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_len(input string nm, input int e, input int g);
    samples_checked++;
    if (g != e) begin
      num_errors++;
      $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
    end
  endtask : chk_len
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {22'h0, idx, 2'h0};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'($random(seed)), d};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wait_evt(input logic cal, input int lim, output int k);
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while ((cal ? cal_done : done) !== 1'b1 && k < lim);
  endtask : wait_evt
  function automatic int conv_len(input logic [7:0] c, input logic two);
    return c[7] ? c[6:0] * 128 + 248 + two : c[6:0] * 64 + 206 + two;
  endfunction : conv_len
  initial begin
    {srst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 8'h00);
      chk_val("reset value", {24'h0, re[i]}, rd);
    end
    sc = '{8'h82, 8'h03, 8'h7F, {1'b1, 7'(2 + $unsigned($random(seed)) % 19)}};
    for (int i = 0; i < 4; i++) begin
      ch = i[0];
      bus(1'b1, ch ? ADDR_CONV_TIME1 : ADDR_CONV_TIME0, sc[i]);
      bus(1'b0, ch ? ADDR_CONV_TIME1 : ADDR_CONV_TIME0, 8'h00);
      chk_val("conv time", {24'h0, sc[i]}, rd);
      bus(1'b1, ch ? ADDR_MODE_CH1 : ADDR_MODE, 8'h4B);
      wait_evt(1'b0, 20000, n);
      chk_len("single length", conv_len(sc[i], 1'b0), n);
      chk_val("single channel", {31'h0, ch}, {31'h0, conv_channel});
      bus(1'b0, ADDR_MODE, 8'h00);
      chk_val("mode after single", 32'h0B, rd);
      chk_val("ready pin", 32'h0, {31'h0, rdy_n});
    end
    bus(1'b1, ADDR_CHAN_SETUP0, 8'h08);
    bus(1'b1, ADDR_CONV_TIME0, 8'h84);
    bus(1'b1, ADDR_CONV_TIME1, 8'h05);
    for (int k = 0; k < 5; k++) begin
      if (k == 0) bus(1'b1, ADDR_MODE, 8'h20);
      if (k == 2) bus(1'b1, ADDR_CHAN_SETUP1, 8'h08);
      if (k == 2) bus(1'b1, ADDR_MODE_CH1, 8'h26);
      ch = (k == 2 || k == 4);
      wait_evt(1'b0, 2000, n);
      chk_len("cont length", conv_len(ch ? 8'h05 : 8'h84, k > 1), n);
      chk_val("cont channel", {31'h0, ch}, {31'h0, conv_channel});
    end
    repeat (100) @(posedge mclk);
    bus(1'b1, ADDR_MODE, 8'h00);
    #1;
    chk_val("ready after write", 32'h1, {31'h0, rdy_n});
    bus(1'b1, ADDR_CHAN_SETUP1, 8'h00);
    bus(1'b1, ADDR_CONV_TIME0, 8'h82);
    for (int c = 0; c < 8; c++) begin
      md = {c[2:0], 5'($random(seed))};
      bus(1'b1, ADDR_MODE, md);
      wait_evt(c == 4 || c > 5, 1200, n);
      chk_len("mode event", c == 4 || c > 5 ? 1008 : (c == 1 || c == 2) ? 504 : 1200, n);
      bus(1'b0, ADDR_MODE, 8'h00);
      chk_val("mode readback", (c == 2 || c == 4 || c > 5) ? md & 8'h1F : md, rd);
    end
    bus(1'b1, ADDR_CONV_CTRL, 8'h01);
    bus(1'b1, ADDR_MODE, 8'h50);
    wait_evt(1'b0, 1200, n);
    chk_len("frozen clock", 1200, n);
    chk_val("oscillator", 32'h0, {31'h0, osc});
    test_done();
  end
endmodule : tb_adc_mode_and_conversion_timing
